// *** design/retimer_irq_pkg.sv ***
package retimer_irq_pkg;

  // ----------------------------------------------------------------
  // Shared register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] SHARED_RESET_EEPROM_CTRL = 8'h04;
  localparam logic [7:0] SHARED_IRQ_CHANNEL_FLAGS = 8'h05;
  localparam logic [7:0] CHANNEL_SELECT = 8'hff;
  localparam int SHARED_RESET_BIT = 6;
  localparam int MM_RESET_BIT = 5;
  localparam int IMM_READ_BIT = 4;
  localparam int MASTER_DISABLE_BIT = 7;
  localparam int LOAD_DONE_BIT = 4;

  // ----------------------------------------------------------------
  // Channel register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CHANNEL_SOFT_RESET_CTRL = 8'h00;
  localparam logic [7:0] CHANNEL_LOCK_SIGNAL_FLAGS = 8'h01;
  localparam logic [7:0] CDR_RESET_OVERRIDE = 8'h0a;
  localparam logic [7:0] EYE_IRQ_STATUS = 8'h30;
  localparam logic [7:0] ADAPTATION_SELECT = 8'h31;
  localparam logic [7:0] EYE_IRQ_THRESHOLD = 8'h32;
  localparam logic [7:0] EYE_IRQ_ENABLE_CTRL = 8'h36;
  localparam int CHANNEL_RESET_BIT = 2;
  localparam int LOL_FLAG_BIT = 4;
  localparam int LOS_FLAG_BIT = 0;
  localparam int CDR_OVR_EN_BIT = 3;
  localparam int CDR_OVR_RST_BIT = 2;
  localparam int EYE_FLAG_BIT = 4;
  localparam int ADAPT_LSB = 5;
  localparam int EYE_IRQ_EN_BIT = 6;
  localparam int HORIZ_TH_LSB = 4;
  localparam int VERT_TH_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CHANNEL_SELECT_RST = 8'h00;
  localparam logic [1:0] ADAPT_RST = 2'h0;
  localparam logic [7:0] EYE_TH_RST = 8'h00;

  // ----------------------------------------------------------------
  // Register access carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef enum logic [1:0] {
    LD_IDLE,
    LD_BUSY,
    LD_DONE
  } load_state_type;

endpackage

// *** design/retimer_irq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Writing shared_reset_eeprom_ctrl bit 6 restores shared control registers; self-clearing.
// - shared_reset_eeprom_ctrl bit 5 re-arms EEPROM loading; pin fall then loads in master mode.
// - Master mode loads EEPROM on load pin fall; completion sets shared_irq_channel_flags bit 4.
// - Writing shared_reset_eeprom_ctrl bit 4 starts an EEPROM load at once, any mode.
// - After a completed load, bit 4 is ignored until bit 5 re-arms.
// - After re-arm, either pin fall (master mode only) or bit 4 starts the load.
// - shared_irq_channel_flags bit 7 blocks starting a load; running or done loads unaffected.
// - Channel_soft_reset_ctrl bit 2 restores the channel's registers; self-clearing.
// - Cdr_reset_override bit 3 enables override, bit 2 holds CDR in reset.
// - After CDR release the channel locks and adapts per 0x31 bits 6:5.
// - Loss of lock or loss of signal always raises a channel interrupt.
// - With 0x36 bit 6 set, eye opening below threshold raises an interrupt.
// - Eye interrupt, judged against 0x32 thresholds, sets 0x30 bit 4.
// - Any pending channel interrupt pulls the open-drain interrupt line low.
// - Lock loss sets 0x01 bit 4, signal loss sets bit 0.
// - shared_irq_channel_flags bits 3:0 show which channels have pending interrupts.
// - Reading channel_lock_signal_flags clears its lock and signal flags.
// - Reading eye_irq_status clears its eye flag.
// - Interrupt line released only when all channel flags are cleared.
// - Eye interrupts are disabled after reset.
// - Strap low/floating at power-up gives master mode, high gives slave.
module retimer_irq_ctrl #(
  parameter int NUM_CH = 4,
  parameter int EYE_W = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register access from the bus slave front end
  input wire retimer_irq_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  // Configuration pins
  input wire logic bus_role_strap_pin,
  input wire logic load_req_n,
  // EEPROM load engine handshake
  output logic ee_load_req,
  input wire logic ee_load_done,
  // Channel status from the analog side
  input wire logic [NUM_CH-1:0] cdr_locked,
  input wire logic [NUM_CH-1:0] signal_detect,
  input wire logic [NUM_CH-1:0][EYE_W-1:0] horizontal_eye_opening,
  input wire logic [NUM_CH-1:0][EYE_W-1:0] vertical_eye_opening,
  // Channel control
  output logic [NUM_CH-1:0] cdr_reset,
  output logic [NUM_CH-1:0][1:0] adapt_mode,
  // Open-drain interrupt request
  output logic irq_n_out,
  output logic irq_n_oe_n
);

  if (NUM_CH < 1 || NUM_CH > 4) begin
    $error("NUM_CH must be 1 to 4");
  end
  if (EYE_W < 1 || EYE_W > 4) begin
    $error("EYE_W must be 1 to 4");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic eye_low(input logic [7:0] th,
                                   input logic [EYE_W-1:0] h_open,
                                   input logic [EYE_W-1:0] v_open);
    logic [3:0] h;
    logic [3:0] v;
    h = 4'h0;
    v = 4'h0;
    h[EYE_W-1:0] = h_open;
    v[EYE_W-1:0] = v_open;
    eye_low = (h < th[retimer_irq_pkg::HORIZ_TH_LSB +: 4]) ||
              (v < th[retimer_irq_pkg::VERT_TH_LSB +: 4]);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic mm_reset_q;
  logic master_dis_q;
  logic [7:0] chsel_q;
  logic master_mode_q;
  logic strap_taken_q;
  logic load_n_prev_q;
  retimer_irq_pkg::load_state_type ld_state_q;
  retimer_irq_pkg::load_state_type ld_state_d;
  logic [NUM_CH-1:0] ovr_en_q;
  logic [NUM_CH-1:0] ovr_rst_q;
  logic [NUM_CH-1:0][1:0] adapt_q;
  logic [NUM_CH-1:0][7:0] eye_th_q;
  logic [NUM_CH-1:0] eye_en_q;
  logic [NUM_CH-1:0] lol_q;
  logic [NUM_CH-1:0] los_q;
  logic [NUM_CH-1:0] eye_q;
  logic [NUM_CH-1:0] locked_prev_q;
  logic [NUM_CH-1:0] sd_prev_q;
  logic [NUM_CH-1:0] eye_low_prev_q;
  logic [7:0] rdata_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic wr = reg_req.wr;
  wire logic rd = reg_req.rd;
  wire logic [7:0] wd = reg_req.wdata;
  wire logic hit_04 =
    reg_req.addr == retimer_irq_pkg::SHARED_RESET_EEPROM_CTRL;
  wire logic hit_05 =
    reg_req.addr == retimer_irq_pkg::SHARED_IRQ_CHANNEL_FLAGS;
  wire logic hit_ff = reg_req.addr == retimer_irq_pkg::CHANNEL_SELECT;
  wire logic shared_hit = hit_04 || hit_05 || hit_ff;
  wire logic shared_reset = wr && hit_04 &&
                            wd[retimer_irq_pkg::SHARED_RESET_BIT];
  wire logic imm_req = wr && hit_04 && wd[retimer_irq_pkg::IMM_READ_BIT];
  logic [NUM_CH-1:0] sel;
  logic [NUM_CH-1:0] ch_wr;
  logic [NUM_CH-1:0] ch_rd;
  logic [NUM_CH-1:0] ch_reset;
  logic [NUM_CH-1:0] lol_ev;
  logic [NUM_CH-1:0] los_ev;
  logic [NUM_CH-1:0] eye_low_now;
  logic [NUM_CH-1:0] eye_ev;
  logic [NUM_CH-1:0] ch_pending;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      sel[c] = chsel_q == 8'(c);
      ch_wr[c] = wr && !shared_hit && sel[c];
      ch_rd[c] = rd && !shared_hit && sel[c];
      ch_reset[c] = ch_wr[c] &&
                    reg_req.addr == retimer_irq_pkg::CHANNEL_SOFT_RESET_CTRL &&
                    wd[retimer_irq_pkg::CHANNEL_RESET_BIT];
      eye_low_now[c] = eye_low(eye_th_q[c], horizontal_eye_opening[c],
                               vertical_eye_opening[c]);
      lol_ev[c] = locked_prev_q[c] && !cdr_locked[c];
      los_ev[c] = sd_prev_q[c] && !signal_detect[c];
      eye_ev[c] = eye_en_q[c] && eye_low_now[c] && !eye_low_prev_q[c];
      ch_pending[c] = lol_q[c] || los_q[c] || eye_q[c];
    end
  end

  wire logic [3:0] ch_flags = 4'(ch_pending);
  wire logic any_pending = |ch_pending;

  // ----------------------------------------------------------------
  // EEPROM load sequencing
  // ----------------------------------------------------------------
  wire logic load_fall = load_n_prev_q && !load_req_n;
  wire logic pin_start = master_mode_q && strap_taken_q && load_fall;
  wire logic start_ok = !master_dis_q;

  always_comb begin
    ld_state_d = ld_state_q;
    case (ld_state_q)
      retimer_irq_pkg::LD_IDLE: begin
        if (start_ok && (pin_start || imm_req)) begin
          ld_state_d = retimer_irq_pkg::LD_BUSY;
        end
      end
      retimer_irq_pkg::LD_BUSY: begin
        if (ee_load_done) begin
          ld_state_d = retimer_irq_pkg::LD_DONE;
        end
      end
      retimer_irq_pkg::LD_DONE: begin
        if (mm_reset_q) begin
          ld_state_d = retimer_irq_pkg::LD_IDLE;
        end
      end
      default: ld_state_d = retimer_irq_pkg::LD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ld_state_q <= retimer_irq_pkg::LD_IDLE;
      load_n_prev_q <= 1'b1;
      strap_taken_q <= 1'b0;
      master_mode_q <= 1'b0;
    end else begin
      ld_state_q <= ld_state_d;
      load_n_prev_q <= load_req_n;
      strap_taken_q <= 1'b1;
      if (!strap_taken_q) begin
        master_mode_q <= !bus_role_strap_pin;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mm_reset_q <= 1'b0;
      master_dis_q <= 1'b0;
      chsel_q <= retimer_irq_pkg::CHANNEL_SELECT_RST;
    end else if (shared_reset) begin
      mm_reset_q <= 1'b0;
      master_dis_q <= 1'b0;
      chsel_q <= retimer_irq_pkg::CHANNEL_SELECT_RST;
    end else if (wr) begin
      if (hit_04) begin
        mm_reset_q <= wd[retimer_irq_pkg::MM_RESET_BIT];
      end
      if (hit_05) begin
        master_dis_q <= wd[retimer_irq_pkg::MASTER_DISABLE_BIT];
      end
      if (hit_ff) begin
        chsel_q <= wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovr_en_q <= '0;
      ovr_rst_q <= '0;
      adapt_q <= '0;
      eye_th_q <= '0;
      eye_en_q <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (ch_reset[c]) begin
          ovr_en_q[c] <= 1'b0;
          ovr_rst_q[c] <= 1'b0;
          adapt_q[c] <= retimer_irq_pkg::ADAPT_RST;
          eye_th_q[c] <= retimer_irq_pkg::EYE_TH_RST;
          eye_en_q[c] <= 1'b0;
        end else if (ch_wr[c]) begin
          case (reg_req.addr)
            retimer_irq_pkg::CDR_RESET_OVERRIDE: begin
              ovr_en_q[c] <= wd[retimer_irq_pkg::CDR_OVR_EN_BIT];
              ovr_rst_q[c] <= wd[retimer_irq_pkg::CDR_OVR_RST_BIT];
            end
            retimer_irq_pkg::ADAPTATION_SELECT: begin
              adapt_q[c] <= wd[retimer_irq_pkg::ADAPT_LSB +: 2];
            end
            retimer_irq_pkg::EYE_IRQ_THRESHOLD: eye_th_q[c] <= wd;
            retimer_irq_pkg::EYE_IRQ_ENABLE_CTRL: begin
              eye_en_q[c] <= wd[retimer_irq_pkg::EYE_IRQ_EN_BIT];
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags: a new event wins over a clearing read
  // ----------------------------------------------------------------
  wire logic rd_01 =
    reg_req.addr == retimer_irq_pkg::CHANNEL_LOCK_SIGNAL_FLAGS;
  wire logic rd_30 = reg_req.addr == retimer_irq_pkg::EYE_IRQ_STATUS;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lol_q <= '0;
      los_q <= '0;
      eye_q <= '0;
      locked_prev_q <= '0;
      sd_prev_q <= '0;
      eye_low_prev_q <= '0;
    end else begin
      locked_prev_q <= cdr_locked;
      sd_prev_q <= signal_detect;
      eye_low_prev_q <= eye_low_now & eye_en_q;
      for (int c = 0; c < NUM_CH; c++) begin
        if (lol_ev[c]) begin
          lol_q[c] <= 1'b1;
        end else if ((ch_rd[c] && rd_01) || ch_reset[c]) begin
          lol_q[c] <= 1'b0;
        end
        if (los_ev[c]) begin
          los_q[c] <= 1'b1;
        end else if ((ch_rd[c] && rd_01) || ch_reset[c]) begin
          los_q[c] <= 1'b0;
        end
        if (eye_ev[c]) begin
          eye_q[c] <= 1'b1;
        end else if ((ch_rd[c] && rd_30) || ch_reset[c]) begin
          eye_q[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_val;

  always_comb begin
    rd_val = 8'h00;
    if (hit_04) begin
      rd_val[retimer_irq_pkg::MM_RESET_BIT] = mm_reset_q;
    end else if (hit_05) begin
      rd_val[retimer_irq_pkg::MASTER_DISABLE_BIT] = master_dis_q;
      rd_val[retimer_irq_pkg::LOAD_DONE_BIT] =
        ld_state_q == retimer_irq_pkg::LD_DONE;
      rd_val[3:0] = ch_flags;
    end else if (hit_ff) begin
      rd_val = chsel_q;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (sel[c]) begin
          case (reg_req.addr)
            retimer_irq_pkg::CHANNEL_LOCK_SIGNAL_FLAGS: begin
              rd_val[retimer_irq_pkg::LOL_FLAG_BIT] = lol_q[c];
              rd_val[retimer_irq_pkg::LOS_FLAG_BIT] = los_q[c];
            end
            retimer_irq_pkg::CDR_RESET_OVERRIDE: begin
              rd_val[retimer_irq_pkg::CDR_OVR_EN_BIT] = ovr_en_q[c];
              rd_val[retimer_irq_pkg::CDR_OVR_RST_BIT] = ovr_rst_q[c];
            end
            retimer_irq_pkg::EYE_IRQ_STATUS: begin
              rd_val[retimer_irq_pkg::EYE_FLAG_BIT] = eye_q[c];
            end
            retimer_irq_pkg::ADAPTATION_SELECT: begin
              rd_val[retimer_irq_pkg::ADAPT_LSB +: 2] = adapt_q[c];
            end
            retimer_irq_pkg::EYE_IRQ_THRESHOLD: rd_val = eye_th_q[c];
            retimer_irq_pkg::EYE_IRQ_ENABLE_CTRL: begin
              rd_val[retimer_irq_pkg::EYE_IRQ_EN_BIT] = eye_en_q[c];
            end
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      rdata_q <= rd_val;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign ee_load_req = ld_state_q == retimer_irq_pkg::LD_BUSY;
  assign cdr_reset = ovr_en_q & ovr_rst_q;
  assign adapt_mode = adapt_q;
  assign irq_n_out = 1'b0;
  assign irq_n_oe_n = !any_pending;

endmodule

`default_nettype wire

// *** bench/retimer_irq_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module retimer_irq_checker #(
  parameter int NUM_CH = 4,
  parameter int EYE_W = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register access
  input wire retimer_irq_pkg::reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  // Load handshake
  input wire logic ee_load_req,
  input wire logic ee_load_done,
  // Channel side
  input wire logic [NUM_CH-1:0] cdr_locked,
  input wire logic [NUM_CH-1:0] signal_detect,
  input wire logic [NUM_CH-1:0] cdr_reset,
  input wire logic [NUM_CH-1:0][1:0] adapt_mode,
  // Interrupt pin
  input wire logic irq_n_out,
  input wire logic irq_n_oe_n
);
  // -----
  // Shadow of select, disable and load idle state
  // -----
  logic [7:0] sel_q;
  logic dis_q;
  logic idle_q;
  wire logic w04 = reg_req.wr && reg_req.addr == 8'h04;
  wire logic wsh = w04 && reg_req.wdata[6];
  wire logic ch_ok = sel_q < NUM_CH;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_q <= 8'h00;
      dis_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      if (wsh) sel_q <= 8'h00;
      else if (reg_req.wr && reg_req.addr == 8'hff) sel_q <= reg_req.wdata;
      if (wsh) dis_q <= 1'b0;
      else if (reg_req.wr && reg_req.addr == 8'h05) dis_q <= reg_req.wdata[7];
      if (ee_load_req) idle_q <= 1'b0;
      else if (w04 && reg_req.wdata[5]) idle_q <= 1'b1;
    end
  end
  // -----
  // Properties
  // -----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_imm_go;
    w04 && reg_req.wdata[4] && !reg_req.wdata[6];
  endsequence
  sequence s_load_end;
    ee_load_req && ee_load_done;
  endsequence
  AST_OD_LOW: assert property (irq_n_out == 1'b0)
    else $error("interrupt data not low");
  AST_LOAD_HOLD: assert property (
    ee_load_req && !ee_load_done |=> ee_load_req)
    else $error("load dropped early");
  AST_LOAD_END: assert property (s_load_end |=> !ee_load_req)
    else $error("load not ended");
  AST_IMM_START: assert property (
    s_imm_go ##0 (idle_q && !dis_q && !ee_load_req) |-> ##[1:2] ee_load_req)
    else $error("immediate load not started");
  AST_NO_REPEAT: assert property (
    s_imm_go ##0 (!idle_q && !ee_load_req) |=> !ee_load_req [*3])
    else $error("load repeated without re-arm");
  AST_DIS_BLOCK: assert property (
    s_imm_go ##0 (idle_q && dis_q && !ee_load_req) |=> !ee_load_req [*3])
    else $error("load started while disabled");
  AST_PEND_PULLS: assert property (
    reg_req.rd && reg_req.addr == 8'h05
    |=> reg_rdata[3:0] == 4'h0 || !irq_n_oe_n)
    else $error("pending channel without line low");
  AST_LOSS_IRQ: assert property (
    |(($past(cdr_locked) & ~cdr_locked)
    | ($past(signal_detect) & ~signal_detect)) |-> ##[0:2] !irq_n_oe_n)
    else $error("loss event without interrupt");
  AST_CDR_OVR: assert property (
    reg_req.wr && reg_req.addr == 8'h0a && ch_ok
    |=> cdr_reset[sel_q] ==
    ($past(reg_req.wdata[3]) && $past(reg_req.wdata[2])))
    else $error("cdr reset not per override bits");
  AST_CH_RESET: assert property (
    reg_req.wr && reg_req.addr == 8'h00 && reg_req.wdata[2] && ch_ok
    |=> cdr_reset[sel_q] == 1'b0 && adapt_mode[sel_q] == 2'h0)
    else $error("channel reset left controls set");
endmodule
bind retimer_irq_ctrl retimer_irq_checker #(
  .NUM_CH(NUM_CH),
  .EYE_W(EYE_W)
) retimer_irq_checker_inst (
  .core_clk, .rst, .reg_req, .reg_rdata, .ee_load_req, .ee_load_done,
  .cdr_locked, .signal_detect, .cdr_reset, .adapt_mode, .irq_n_out,
  .irq_n_oe_n
);
`default_nettype wire

// *** bench/retimer_ee_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module retimer_ee_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Load handshake
  input wire logic ee_load_req,
  input wire logic slow,
  output logic ee_load_done
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  // A programmed image is always present, so every load ends in done
  assign cnt_d = (ee_load_req && !ee_load_done) ? cnt_q + 4'h1 : 4'h0;
  assign ee_load_done = ee_load_req && cnt_q == (slow ? 4'hc : 4'h1);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) cnt_q <= 4'h0;
    else cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

// *** bench/test_retimer_irq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_retimer_irq_ctrl;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic bus_role_strap_pin = 1'b0;
  logic load_req_n = 1'b1;
  logic slow = 1'b0;
  retimer_irq_pkg::reg_req_type reg_req = '0;
  logic [3:0] cdr_locked = 4'hf;
  logic [3:0] signal_detect = 4'hf;
  logic [3:0][3:0] horizontal_eye_opening = 16'hffff;
  logic [3:0][3:0] vertical_eye_opening = 16'hffff;
  logic [7:0] reg_rdata;
  logic ee_load_req;
  logic ee_load_done;
  logic [3:0] cdr_reset;
  logic [3:0][1:0] adapt_mode;
  logic irq_n_out;
  logic irq_n_oe_n;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  retimer_irq_ctrl #(.NUM_CH(4), .EYE_W(4)) retimer_irq_ctrl_inst (
    .core_clk, .rst, .reg_req, .reg_rdata, .bus_role_strap_pin, .load_req_n,
    .ee_load_req, .ee_load_done, .cdr_locked, .signal_detect,
    .horizontal_eye_opening, .vertical_eye_opening, .cdr_reset, .adapt_mode,
    .irq_n_out, .irq_n_oe_n
  );
  retimer_ee_model retimer_ee_model_inst (
    .core_clk, .rst, .ee_load_req, .slow, .ee_load_done
  );
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  // -----
  // Bus and compare helpers
  // -----
  task test_done;
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge core_clk);
    reg_req.wr = 1'b0;
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge core_clk);
    reg_req.rd = 1'b0;
    chk(n, reg_rdata, e);
  endtask
  task wait_req(input logic lvl);
    for (int i = 0; i < 40 && ee_load_req !== lvl; i++) @(negedge core_clk);
    chk("load_req", {7'h00, ee_load_req}, {7'h00, lvl});
  endtask
  task rearm;
    wr(8'h04, 8'h20);
    wr(8'h04, 8'h00);
  endtask
  // -----
  // Scenarios
  // -----
  task t_regs;
    rchk("sel_rst", 8'hff, 8'h00);
    rchk("eye_en_rst", 8'h36, 8'h00);
    rchk("pend_rst", 8'h05, 8'h00);
    wr(8'hff, 8'h07);
    wr(8'h31, 8'h60);
    rchk("refused", 8'h31, 8'h00);
    chk("adapt_rst", adapt_mode, 8'h00);
    wr(8'hff, 8'h00);
    rchk("unmapped", 8'h77, 8'h00);
  endtask
  task t_cdr;
    wr(8'hff, 8'h01);
    wr(8'h0a, 8'h0c);
    chk("cdr_hold", {4'h0, cdr_reset}, 8'h02);
    wr(8'h31, 8'h60);
    chk("adapt", {6'h00, adapt_mode[1]}, 8'h03);
    wr(8'h0a, 8'h08);
    chk("cdr_free", {4'h0, cdr_reset}, 8'h00);
    wr(8'h0a, 8'h0c);
    wr(8'h00, 8'h04);
    chk("ch_rst", {2'h0, cdr_reset, adapt_mode[1]}, 8'h00);
    rchk("ch_rst_bit", 8'h00, 8'h00);
    rchk("ovr_reg", 8'h0a, 8'h00);
  endtask
  task t_irq;
    cdr_locked = 4'ha;
    signal_detect[2] = 1'b0;
    hold(3);
    chk("irq_low", {7'h00, irq_n_oe_n}, 8'h00);
    chk("irq_data", {7'h00, irq_n_out}, 8'h00);
    rchk("pend", 8'h05, 8'h05);
    wr(8'hff, 8'h02);
    rchk("ch2_flags", 8'h01, 8'h11);
    rchk("pend_ch0", 8'h05, 8'h01);
    chk("irq_held", {7'h00, irq_n_oe_n}, 8'h00);
    wr(8'hff, 8'h00);
    rchk("ch0_flags", 8'h01, 8'h10);
    rchk("ch0_clear", 8'h01, 8'h00);
    chk("irq_free", {7'h00, irq_n_oe_n}, 8'h01);
    cdr_locked = 4'hf;
    signal_detect = 4'hf;
  endtask
  task t_eye;
    wr(8'hff, 8'h03);
    wr(8'h32, 8'h88);
    vertical_eye_opening[3] = 4'h2;
    hold(3);
    chk("eye_off", {7'h00, irq_n_oe_n}, 8'h01);
    vertical_eye_opening[3] = 4'hf;
    wr(8'h36, 8'h40);
    horizontal_eye_opening[3] = 4'h8;
    hold(3);
    chk("eye_edge", {7'h00, irq_n_oe_n}, 8'h01);
    horizontal_eye_opening[3] = 4'h7;
    hold(3);
    chk("eye_irq", {7'h00, irq_n_oe_n}, 8'h00);
    rchk("pend_eye", 8'h05, 8'h08);
    rchk("eye_src", 8'h30, 8'h10);
    chk("eye_free", {7'h00, irq_n_oe_n}, 8'h01);
    horizontal_eye_opening[3] = 4'hf;
    hold(2);
    vertical_eye_opening[3] = 4'h7;
    hold(3);
    rchk("eye_vert", 8'h30, 8'h10);
    rchk("eye_clear", 8'h30, 8'h00);
    horizontal_eye_opening = 16'hffff;
    vertical_eye_opening = 16'hffff;
    wr(8'h36, 8'h00);
  endtask
  task t_load;
    wr(8'h04, 8'h10);
    wait_req(1'b1);
    wait_req(1'b0);
    rchk("load_done", 8'h05, 8'h10);
    wr(8'h04, 8'h10);
    hold(4);
    chk("load_again", {7'h00, ee_load_req}, 8'h00);
    rearm();
    rchk("rearm", 8'h05, 8'h00);
    slow = 1'b1;
    load_req_n = 1'b0;
    wait_req(1'b1);
    load_req_n = 1'b1;
    wr(8'h05, 8'h80);
    chk("load_busy", {7'h00, ee_load_req}, 8'h01);
    wait_req(1'b0);
    rchk("load_slow", 8'h05, 8'h90);
    rearm();
    wr(8'h04, 8'h10);
    load_req_n = 1'b0;
    hold(4);
    load_req_n = 1'b1;
    chk("load_block", {7'h00, ee_load_req}, 8'h00);
    wr(8'h04, 8'h40);
    rchk("sh_rst", 8'h05, 8'h00);
    rchk("sh_bit", 8'h04, 8'h00);
    wr(8'h04, 8'h10);
    wait_req(1'b1);
    wait_req(1'b0);
  endtask
  task t_slave;
    rst = 1'b1;
    bus_role_strap_pin = 1'b1;
    hold(2);
    rst = 1'b0;
    hold(2);
    load_req_n = 1'b0;
    hold(4);
    load_req_n = 1'b1;
    chk("slave_pin", {7'h00, ee_load_req}, 8'h00);
    rchk("slave_done", 8'h05, 8'h00);
    wr(8'h04, 8'h10);
    wait_req(1'b1);
    wait_req(1'b0);
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    t_regs();
    t_cdr();
    t_irq();
    t_eye();
    t_load();
    t_slave();
    test_done();
  end
endmodule
`default_nettype wire
